// ==== rtl/ucr_channel.sv ====
// uart channel: host registers, transmit fifo, serializer and receiver
//
// Behaviour
// - activate bit clears on any power-on, host bus or soft reset.
// - serial output released (not driven) while activate bit is zero.
// - active and idle transmitter drives serial output high unless send break is set.
// - active and busy, loop and send break clear: serial output carries the transmit bit stream.
// - offset 0, bank clear: read gives received byte, write queues byte.
// - line setup bit 7 banks divisor low/high bytes onto offsets 0, 1.
// - offset 1 holds four interrupt enables; bits 7..4 read zero.
// - offset 2 read: pending low, id in 3..1, 5..4 zero, fifo flags.
// - non-fifo mode: fifo flags, top id bit, fifo error read zero.
// - offset 2 write: enable, rx reset, tx reset, mode, trigger.
// - transfer-mode select bit written as one has no effect.
// - every fifo setup write copied to shadow at 0x20 plus CHANNEL.
// - modem outputs: aux bits (no pin; ring and carrier status in loop), loop, rts and dtr.
// - line condition: ready, overrun, parity, framing, break, empties.
// - legacy mode: transmitter-empty follows shift register alone.
// - scratch byte stores writes; unavailable in legacy mode.
// - bit 0 is shifted first on transmit and receive.
`timescale 1ns/1ps
`default_nettype none

module ucr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + AW'(1);
      if (pop)  rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + AW'(1);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ucr_fifo

module ucr_channel #(
  parameter int         FIFO_DEPTH = ucr_pkg::UCR_TX_DEPTH,
  parameter logic [5:0] CHANNEL    = 6'h00
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [5:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [7:0]         rdata,
  input  wire logic               activate_wr,
  input  wire logic               activate_din,
  input  wire logic               standby_power_on_reset,
  input  wire logic               main_power_on_reset,
  input  wire logic               host_bus_reset,
  input  wire logic               soft_reset,
  input  wire logic               legacy_compat_mode,
  input  wire ucr_pkg::ucr_modem_t modem_in,
  input  wire logic               serial_in,
  output logic                    serial_out_channel_one,
  output logic                    serial_out_channel_one_oe,
  output logic                    rts_out,
  output logic                    dtr_out,
  output logic                    channel_active,
  output logic      [7:0]         fifo_setup_shadow
);
  import ucr_pkg::*;

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  ucr_line_t   line_setup;
  logic [15:0] divisor;
  logic [3:0]  interrupt_enables;
  logic        fifo_on;
  logic [2:0]  iir_id;
  logic [4:0]  modem_outputs;
  logic [7:0]  scratch_byte;
  logic [7:0]  receive_buffer;
  logic        rx_byte_present;
  logic        overrun;
  logic        parity_fault;
  logic        framing_fault;
  logic        break_seen;
  logic        tx_space_pending;
  logic        tx_empty_q;
  ucr_modem_t  modem_q;
  logic        cts_changed;
  logic        dsr_changed;
  logic        ring_trailing_edge;
  logic        carrier_changed;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire bank     = line_setup.divisor_bank_select;
  wire loop     = modem_outputs[UCR_MCR_LOOP];
  wire wr_thr   = wr & (addr == UCR_OFS_DATA) & ~bank;
  wire wr_dll   = wr & (addr == UCR_OFS_DATA) & bank;
  wire wr_dlm   = wr & (addr == UCR_OFS_IEN) & bank;
  wire wr_ier   = wr & (addr == UCR_OFS_IEN) & ~bank;
  wire wr_fcr   = wr & (addr == UCR_OFS_IID);
  wire wr_lcr   = wr & (addr == UCR_OFS_LINE);
  wire wr_mcr   = wr & (addr == UCR_OFS_MOUT);
  wire wr_scr   = wr & (addr == UCR_OFS_SCRATCH) & ~legacy_compat_mode;
  wire rd_rbr   = rd & (addr == UCR_OFS_DATA) & ~bank;
  wire rd_iir   = rd & (addr == UCR_OFS_IID);
  wire rd_lsr   = rd & (addr == UCR_OFS_LSTAT);
  wire rd_msr   = rd & (addr == UCR_OFS_MIN);
  wire rx_flush = wr_fcr & (wdata[UCR_FCR_RXRST] | (wdata[UCR_FCR_EN] != fifo_on));
  wire tx_flush = wr_fcr & (wdata[UCR_FCR_TXRST] | (wdata[UCR_FCR_EN] != fifo_on));
  wire any_rst  = standby_power_on_reset | main_power_on_reset
                | host_bus_reset | soft_reset;

  // -------------------------------------------------------------------
  // transmit fifo
  // -------------------------------------------------------------------
  logic       f_out_valid;
  logic [7:0] f_out_data;
  logic       tx_pop;
  // without fifo mode the queue holds one byte; a write with no room is lost
  wire        tx_accept = wr_thr & (fifo_on | ~f_out_valid);

  ucr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk       (clk),
    .srst      (srst),
    .flush     (tx_flush),
    .in_valid  (tx_accept),
    .in_ready  (),
    .in_data   (wdata),
    .out_valid (f_out_valid),
    .out_ready (tx_pop),
    .out_data  (f_out_data)
  );

  // -------------------------------------------------------------------
  // baud tick at sixteen times the bit rate
  // -------------------------------------------------------------------
  logic [15:0] bcnt;
  wire         tick = (divisor != 16'h0000)
                   && (bcnt <= 16'h0001 || bcnt > divisor);

  always_ff @(posedge clk) begin
    if (srst) bcnt <= 16'h0000;
    else      bcnt <= tick ? divisor : bcnt - 16'h0001;
  end

  // parity bit for the selected character length
  function automatic logic par_of(input logic [7:0] d, input ucr_line_t l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - {l.char_len_hi, l.char_len_lo}));
    return l.stick_parity ? ~l.parity_even
                          : (l.parity_even ? ^m : ~^m);
  endfunction : par_of

  wire [2:0] last_bit = 3'h4 + {1'b0, line_setup.char_len_hi,
                                line_setup.char_len_lo};

  // -------------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------------
  ucr_state_t tx_st;
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic       tx_par;
  logic       tx_stop2;
  wire        tx_bit_end = tick & (tx_sub == UCR_OVERSAMPLE);

  assign tx_pop = (tx_st == UCR_IDLE) & f_out_valid;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_st    <= UCR_IDLE;
      tx_sub   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= UCR_ZERO_BYTE;
      tx_par   <= 1'b0;
      tx_stop2 <= 1'b0;
    end else begin
      if (tick) tx_sub <= tx_sub + 4'h1;
      case (tx_st)
        UCR_IDLE: begin
          if (f_out_valid) begin
            tx_st  <= UCR_START;
            tx_sh  <= f_out_data;
            tx_par <= par_of(f_out_data, line_setup);
            tx_sub <= 4'h0;
          end
        end
        UCR_START: begin
          if (tx_bit_end) begin
            tx_st  <= UCR_DATA;
            tx_bit <= 3'h0;
          end
        end
        UCR_DATA: begin
          if (tx_bit_end) begin
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == last_bit) begin
              tx_st    <= line_setup.parity_on ? UCR_PAR : UCR_STOP;
              tx_stop2 <= line_setup.stop_bit_count;
            end
          end
        end
        UCR_PAR: begin
          if (tx_bit_end) tx_st <= UCR_STOP;
        end
        UCR_STOP: begin
          if (tx_bit_end) begin
            tx_stop2 <= 1'b0;
            if (!tx_stop2) tx_st <= UCR_IDLE;
          end
        end
        default: tx_st <= UCR_IDLE;
      endcase
    end
  end

  logic tx_line;
  always_comb begin
    case (tx_st)
      UCR_START: tx_line = 1'b0;
      UCR_DATA:  tx_line = tx_sh[0];
      UCR_PAR:   tx_line = tx_par;
      default:   tx_line = 1'b1;
    endcase
  end

  // -------------------------------------------------------------------
  // serial pin and activate bit
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || any_rst) channel_active <= 1'b0;
    else if (activate_wr) channel_active <= activate_din;
  end

  // in loopback the pin idles high unless send break is set; the stream turns inward
  assign serial_out_channel_one    = line_setup.send_break ? 1'b0
                                   : (loop ? 1'b1 : tx_line);
  assign serial_out_channel_one_oe = channel_active;

  // -------------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------------
  ucr_state_t rx_st;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_pbad;
  logic       rx_pzero;
  logic       rx_done;
  logic       rx_fe;
  logic       rx_bi;
  wire        rx_in      = loop ? tx_line : serial_in;
  wire        rx_sample  = tick & (rx_sub == UCR_OVERSAMPLE);

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st    <= UCR_IDLE;
      rx_sub   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_sh    <= UCR_ZERO_BYTE;
      rx_pbad  <= 1'b0;
      rx_pzero <= 1'b1;
      rx_done  <= 1'b0;
      rx_fe    <= 1'b0;
      rx_bi    <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) rx_sub <= rx_sub + 4'h1;
      case (rx_st)
        UCR_IDLE: begin
          if (!rx_in) begin
            rx_st    <= UCR_START;
            rx_sub   <= 4'h0;
            rx_sh    <= UCR_ZERO_BYTE;
            rx_pbad  <= 1'b0;
            rx_pzero <= 1'b1;
          end
        end
        UCR_START: begin
          // realign to mid-bit; a glitch shorter than half a bit is dropped
          if (tick && rx_sub == UCR_MID_BIT) begin
            rx_st  <= rx_in ? UCR_IDLE : UCR_DATA;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
          end
        end
        UCR_DATA: begin
          if (rx_sample) begin
            rx_sh[rx_bit] <= rx_in;
            rx_bit        <= rx_bit + 3'h1;
            if (rx_bit == last_bit)
              rx_st <= line_setup.parity_on ? UCR_PAR : UCR_STOP;
          end
        end
        UCR_PAR: begin
          if (rx_sample) begin
            rx_pbad  <= (rx_in != par_of(rx_sh, line_setup));
            rx_pzero <= ~rx_in;
            rx_st    <= UCR_STOP;
          end
        end
        UCR_STOP: begin
          if (rx_sample) begin
            rx_fe   <= ~rx_in;
            rx_bi   <= ~rx_in & (rx_sh == UCR_ZERO_BYTE) & rx_pzero;
            rx_done <= 1'b1;
            rx_st   <= UCR_IDLE;
          end
        end
        default: rx_st <= UCR_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // status flags: a setting event wins over a clear in the same cycle
  // -------------------------------------------------------------------
  wire tx_empty = ~f_out_valid;
  ucr_modem_t m_eff;
  assign m_eff = loop ? ucr_modem_t'({modem_outputs[UCR_MCR_AUXB],
                                      modem_outputs[UCR_MCR_AUXA],
                                      modem_outputs[UCR_MCR_DTR],
                                      modem_outputs[UCR_MCR_RTS]})
                      : modem_in;

  always_ff @(posedge clk) begin
    if (srst) begin
      receive_buffer     <= UCR_ZERO_BYTE;
      rx_byte_present    <= 1'b0;
      overrun            <= 1'b0;
      parity_fault       <= 1'b0;
      framing_fault      <= 1'b0;
      break_seen         <= 1'b0;
      tx_space_pending   <= 1'b0;
      tx_empty_q         <= 1'b1;
      modem_q            <= '0;
      cts_changed        <= 1'b0;
      dsr_changed        <= 1'b0;
      ring_trailing_edge <= 1'b0;
      carrier_changed    <= 1'b0;
    end else begin
      if (rx_done) receive_buffer <= rx_sh;
      rx_byte_present <= rx_done | (rx_byte_present & ~rd_rbr & ~rx_flush);
      overrun       <= (rx_done & rx_byte_present & ~rd_rbr) | (overrun & ~rd_lsr);
      parity_fault  <= (rx_done & rx_pbad) | (parity_fault & ~rd_lsr);
      framing_fault <= (rx_done & rx_fe) | (framing_fault & ~rd_lsr);
      break_seen    <= (rx_done & rx_bi) | (break_seen & ~rd_lsr);
      tx_empty_q    <= tx_empty;
      tx_space_pending <= (tx_empty & ~tx_empty_q)
                        | (tx_space_pending & ~tx_accept
                           & ~(rd_iir & (iir_id == UCR_ID_TX)));
      modem_q <= m_eff;
      cts_changed     <= (m_eff.cts != modem_q.cts) | (cts_changed & ~rd_msr);
      dsr_changed     <= (m_eff.dsr != modem_q.dsr) | (dsr_changed & ~rd_msr);
      ring_trailing_edge <= (modem_q.ri & ~m_eff.ri)
                          | (ring_trailing_edge & ~rd_msr);
      carrier_changed <= (m_eff.dcd != modem_q.dcd)
                       | (carrier_changed & ~rd_msr);
    end
  end

  // -------------------------------------------------------------------
  // interrupt identification, highest priority first
  // -------------------------------------------------------------------
  wire line_err = overrun | parity_fault | framing_fault | break_seen;
  wire int_line = interrupt_enables[2] & line_err;
  wire int_rx   = interrupt_enables[0] & rx_byte_present;
  wire int_tx   = interrupt_enables[1] & tx_space_pending;
  wire int_mdm  = interrupt_enables[3] & (cts_changed | dsr_changed
                  | ring_trailing_edge | carrier_changed);
  wire pending  = int_line | int_rx | int_tx | int_mdm;
  assign iir_id = int_line ? UCR_ID_LINE : int_rx ? UCR_ID_RX
                : int_tx ? UCR_ID_TX : UCR_ID_MDM;

  // no character timeout, so the top id bit reads zero
  wire [7:0] iir_val = {{2{fifo_on}}, 2'b00, iir_id, ~pending};
  wire tx_all_empty  = legacy_compat_mode ? (tx_st == UCR_IDLE)
                     : tx_empty & (tx_st == UCR_IDLE);
  wire [7:0] lsr_val = {fifo_on & (parity_fault | framing_fault | break_seen),
                        tx_all_empty, tx_empty, break_seen, framing_fault,
                        parity_fault, overrun, rx_byte_present};
  wire [7:0] msr_val = {modem_q.dcd, modem_q.ri, modem_q.dsr, modem_q.cts,
                        carrier_changed, ring_trailing_edge,
                        dsr_changed, cts_changed};

  // -------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      line_setup        <= '0;
      divisor           <= 16'h0000;
      interrupt_enables <= 4'h0;
      fifo_on           <= 1'b0;
      modem_outputs     <= 5'h00;
      scratch_byte      <= UCR_ZERO_BYTE;
      fifo_setup_shadow <= UCR_ZERO_BYTE;
    end else begin
      if (wr_lcr) line_setup <= ucr_line_t'(wdata);
      if (wr_dll) divisor[7:0]  <= wdata;
      if (wr_dlm) divisor[15:8] <= wdata;
      if (wr_ier) interrupt_enables <= wdata[3:0];
      if (wr_fcr) begin
        // only the enable is kept: no dma mode, no receive fifo to trigger
        fifo_on           <= wdata[UCR_FCR_EN];
        fifo_setup_shadow <= wdata;
      end
      if (wr_mcr) modem_outputs <= wdata[4:0];
      if (wr_scr) scratch_byte  <= wdata;
    end
  end

  // aux bits drive no pin; loopback holds the modem lines inactive
  assign rts_out = modem_outputs[UCR_MCR_RTS] & ~loop;
  assign dtr_out = modem_outputs[UCR_MCR_DTR] & ~loop;

  // -------------------------------------------------------------------
  // read mux, answer in the following cycle
  // -------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    if (addr == UCR_OFS_DATA)
      rd_mux = bank ? divisor[7:0] : receive_buffer;
    else if (addr == UCR_OFS_IEN)
      rd_mux = bank ? divisor[15:8] : {4'h0, interrupt_enables};
    else if (addr == UCR_OFS_IID)
      rd_mux = iir_val;
    else if (addr == UCR_OFS_LINE)
      rd_mux = line_setup;
    else if (addr == UCR_OFS_MOUT)
      rd_mux = {3'h0, modem_outputs};
    else if (addr == UCR_OFS_LSTAT)
      rd_mux = lsr_val;
    else if (addr == UCR_OFS_MIN)
      rd_mux = msr_val;
    else if (addr == UCR_OFS_SCRATCH)
      rd_mux = legacy_compat_mode ? UCR_ZERO_BYTE : scratch_byte;
    else if (addr == UCR_OFS_SHADOW0 + CHANNEL)
      rd_mux = fifo_setup_shadow;
    else
      rd_mux = UCR_ZERO_BYTE;
  end

  always_ff @(posedge clk) begin
    if (srst)    rdata <= UCR_ZERO_BYTE;
    else if (rd) rdata <= rd_mux;
  end

endmodule : ucr_channel

`default_nettype wire

// ==== rtl/ucr_pkg.sv ====
// constants, offsets and carrier types for one uart channel
package ucr_pkg;

  // register offsets on the host port
  localparam logic [5:0] UCR_OFS_DATA    = 6'h00;
  localparam logic [5:0] UCR_OFS_IEN     = 6'h01;
  localparam logic [5:0] UCR_OFS_IID     = 6'h02;
  localparam logic [5:0] UCR_OFS_LINE    = 6'h03;
  localparam logic [5:0] UCR_OFS_MOUT    = 6'h04;
  localparam logic [5:0] UCR_OFS_LSTAT   = 6'h05;
  localparam logic [5:0] UCR_OFS_MIN     = 6'h06;
  localparam logic [5:0] UCR_OFS_SCRATCH = 6'h07;
  localparam logic [5:0] UCR_OFS_SHADOW0 = 6'h20;

  // field positions
  localparam int UCR_FCR_EN      = 0;
  localparam int UCR_FCR_RXRST   = 1;
  localparam int UCR_FCR_TXRST   = 2;
  localparam int UCR_MCR_DTR     = 0;
  localparam int UCR_MCR_RTS     = 1;
  localparam int UCR_MCR_AUXA    = 2;
  localparam int UCR_MCR_AUXB    = 3;
  localparam int UCR_MCR_LOOP    = 4;

  // interrupt identifiers, bits 3..1 of the identification byte
  localparam logic [2:0] UCR_ID_LINE = 3'h3;
  localparam logic [2:0] UCR_ID_RX   = 3'h2;
  localparam logic [2:0] UCR_ID_TX   = 3'h1;
  localparam logic [2:0] UCR_ID_MDM  = 3'h0;

  // timing and sizes
  localparam int         UCR_TX_DEPTH   = 8;
  localparam logic [3:0] UCR_OVERSAMPLE = 4'hF;
  localparam logic [3:0] UCR_MID_BIT    = 4'h7;
  localparam logic [7:0] UCR_ZERO_BYTE  = 8'h00;

  typedef struct packed {
    logic       divisor_bank_select;
    logic       send_break;
    logic       stick_parity;
    logic       parity_even;
    logic       parity_on;
    logic       stop_bit_count;
    logic       char_len_hi;
    logic       char_len_lo;
  } ucr_line_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ucr_modem_t;

  // gray coded along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    UCR_IDLE  = 3'b000,
    UCR_START = 3'b001,
    UCR_DATA  = 3'b011,
    UCR_PAR   = 3'b010,
    UCR_STOP  = 3'b110
  } ucr_state_t;

endpackage : ucr_pkg

// ==== test/ucr_channel_monitor.sv ====
// port checker for the uart channel
`timescale 1ns/1ps
`default_nettype none
module ucr_channel_monitor (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       activate_wr,
  input wire logic       activate_din,
  input wire logic       standby_power_on_reset,
  input wire logic       main_power_on_reset,
  input wire logic       host_bus_reset,
  input wire logic       soft_reset,
  input wire logic       legacy_compat_mode,
  input wire logic       serial_out_channel_one,
  input wire logic       serial_out_channel_one_oe,
  input wire logic       rts_out,
  input wire logic       dtr_out,
  input wire logic       channel_active,
  input wire logic [7:0] fifo_setup_shadow
);
  import ucr_pkg::*;
  wire any_rst = standby_power_on_reset | main_power_on_reset
               | host_bus_reset | soft_reset;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  act_clear_a: assert property (any_rst |=> !channel_active)
    else $error("activate kept");
  act_load_a: assert property (activate_wr && !any_rst
    |=> channel_active == $past(activate_din))
    else $error("activate not loaded");
  pin_release_a: assert property (
    serial_out_channel_one_oe == channel_active)
    else $error("oe not activate bit");
  idle_high_a: assert property ($fell(srst) |-> serial_out_channel_one)
    else $error("idle not high");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("rdata moved");
  iir_zero_a: assert property (rd && addr == UCR_OFS_IID
    |=> rdata[5:4] == 2'h0)
    else $error("iir bits 5..4 set");
  nonfifo_zero_a: assert property (rd && addr == UCR_OFS_IID
    && !fifo_setup_shadow[UCR_FCR_EN] |=> (rdata & 8'hC8) == 8'h00)
    else $error("fifo flags in non-fifo");
  shadow_copy_a: assert property (wr && addr == UCR_OFS_IID
    |=> fifo_setup_shadow == $past(wdata))
    else $error("shadow stale");
  modem_pins_a: assert property (wr && addr == UCR_OFS_MOUT
    |=> {rts_out, dtr_out} == ($past(wdata[4]) ? 2'h0 : $past(wdata[1:0])))
    else $error("modem pins wrong");
  legacy_scr_a: assert property (rd && addr == UCR_OFS_SCRATCH
    && legacy_compat_mode |=> rdata == UCR_ZERO_BYTE)
    else $error("scratch seen in legacy");
  cover property (activate_wr && activate_din);
  cover property (wr && addr == UCR_OFS_IID && wdata[UCR_FCR_EN]);
  cover property (rd && addr == UCR_OFS_SCRATCH && legacy_compat_mode);
endmodule : ucr_channel_monitor
`default_nettype wire

// ==== test/ucr_line_peer.sv ====
// serial peer: decodes channel frames and sends frames back
`timescale 1ns/1ps
`default_nettype none
module ucr_line_peer #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       clk,
  input  wire logic       line,
  output logic            rx_line,
  output logic      [7:0] got,
  output logic      [7:0] n_got
);
  initial begin
    rx_line = 1'b1;
    n_got = 8'h00;
    got = 8'h00;
    forever begin
      @(negedge line);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        got[i] = line;
      end
      repeat (BIT_CYC) @(posedge clk);
      n_got = n_got + 8'h01;
    end
  end
  // gap: idle cycles before the start bit
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (gap) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send
endmodule : ucr_line_peer
`default_nettype wire

// ==== test/ucr_channel_test.sv ====
// top testbench for the uart channel
`timescale 1ns/1ps
`default_nettype none
module ucr_channel_test;
  import ucr_pkg::*;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic activate_wr = 1'b0, activate_din = 1'b0, legacy_compat_mode = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00, rdata, fifo_setup_shadow, q, got, n_got, base;
  logic [3:0] rst4 = 4'h0;
  ucr_modem_t modem_in = '0;
  logic serial_in, serial_out_channel_one, serial_out_channel_one_oe;
  logic rts_out, dtr_out, channel_active;
  int num_errors = 0, n_tests = 0;
  // addr, write value, read-back value
  localparam logic [23:0] ROWS [9] = '{24'h07_A5A5, 24'h01_FF0F,
    24'h04_FF1F, 24'h04_0303, 24'h10_5500, 24'h03_8383, 24'h00_0101,
    24'h01_0000, 24'h03_0303};
  // pull-up while the pin is released
  wire line_w = serial_out_channel_one_oe ? serial_out_channel_one : 1'b1;
  ucr_channel u_ucr_channel (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .activate_wr, .activate_din, .standby_power_on_reset(rst4[3]),
    .main_power_on_reset(rst4[2]), .host_bus_reset(rst4[1]),
    .soft_reset(rst4[0]), .legacy_compat_mode, .modem_in, .serial_in,
    .serial_out_channel_one, .serial_out_channel_one_oe, .rts_out,
    .dtr_out, .channel_active, .fifo_setup_shadow);
  ucr_line_peer u_ucr_line_peer (.clk, .line(line_w), .rx_line(serial_in),
    .got, .n_got);
  always #2 clk = ~clk;
  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(logic [5:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic act(logic v);
    @(posedge clk);
    activate_wr <= 1'b1;
    activate_din <= v;
    @(posedge clk);
    activate_wr <= 1'b0;
  endtask : act
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_reg(UCR_OFS_LSTAT, q);
    chk("lsr reset", q, 8'h60);
    rd_reg(UCR_OFS_IID, q);
    chk("iir reset", q, 8'h01);
    chk("oe reset", {7'h0, serial_out_channel_one_oe}, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr_reg(ROWS[i][21:16], ROWS[i][15:8]);
      rd_reg(ROWS[i][21:16], q);
      chk("register row", q, ROWS[i][7:0]);
    end
    chk("modem pins", {6'h0, rts_out, dtr_out}, 8'h03);
    $display("test registers done");
    act(1'b1);
    #1 chk("idle pin", {6'h0, serial_out_channel_one_oe, line_w}, 8'h03);
    wr_reg(UCR_OFS_DATA, 8'h3C);
    repeat (400) if (n_got < 8'h01) @(posedge clk);
    chk("tx byte", got, 8'h3C);
    u_ucr_line_peer.send(8'hA6, 5);
    rd_reg(UCR_OFS_LSTAT, q);
    chk("data ready", q & 8'h01, 8'h01);
    rd_reg(UCR_OFS_DATA, q);
    chk("rx byte", q, 8'hA6);
    $display("test serial done");
    wr_reg(UCR_OFS_IID, 8'hC9);
    chk("shadow", fifo_setup_shadow, 8'hC9);
    rd_reg(UCR_OFS_IID, q);
    chk("iir fifo flags", q & 8'hF8, 8'hC0);
    base = n_got;
    for (int i = 0; i < 12; i++) wr_reg(UCR_OFS_DATA, 8'(i));
    repeat (4000) if (n_got < base + 8'd9) @(posedge clk);
    repeat (40) begin
      rd_reg(UCR_OFS_LSTAT, q);
      if (q[6]) break;
    end
    chk("drained lsr", q, 8'h60);
    chk("accepted bytes", n_got - base, 8'd9);
    chk("last byte", got, 8'h08);
    wr_reg(UCR_OFS_IID, 8'h00);
    rd_reg(UCR_OFS_IID, q);
    chk("non-fifo iir", q & 8'hC8, 8'h00);
    $display("test fifo done");
    modem_in <= 4'hA;
    rd_reg(UCR_OFS_MIN, q);
    rd_reg(UCR_OFS_MIN, q);
    chk("modem inputs", q, 8'hA0);
    legacy_compat_mode <= 1'b1;
    wr_reg(UCR_OFS_SCRATCH, 8'h5A);
    rd_reg(UCR_OFS_SCRATCH, q);
    chk("legacy scratch", q, 8'h00);
    legacy_compat_mode <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      act(1'b1);
      rst4 <= 4'(1 << i);
      @(posedge clk);
      rst4 <= 4'h0;
      #1 chk("act cleared", {6'h0, channel_active,
             serial_out_channel_one_oe}, 8'h00);
    end
    $display("test modem and resets done");
    summarize();
  end
endmodule : ucr_channel_test
bind ucr_channel ucr_channel_monitor u_ucr_channel_monitor (.clk, .srst,
  .addr, .wdata, .wr, .rd, .rdata, .activate_wr, .activate_din,
  .standby_power_on_reset, .main_power_on_reset, .host_bus_reset,
  .soft_reset, .legacy_compat_mode, .serial_out_channel_one,
  .serial_out_channel_one_oe, .rts_out, .dtr_out, .channel_active,
  .fifo_setup_shadow);
`default_nettype wire
